// ===== verilog/pcfp_defines.svh
`ifndef PCFP_DEFINES_SVH
`define PCFP_DEFINES_SVH

// system clock period
`define PCFP_CLK_PERIOD_NS 10
// least hold time of each level before it counts as a symbol
`define PCFP_T_LOW_ADDR_NS 6000
`define PCFP_T_MID_ADDR_NS 6000
`define PCFP_T_STATE_HIGH_NS 20000
// times the programmer keeps; the device only relies on them
`define PCFP_T_MID_AFTER_HIGH_NS 15000
`define PCFP_T_BURN_HIGH_NS 100000
// least time to cycles, rounded up
`define PCFP_NS_TO_CYC(t) (((t) + `PCFP_CLK_PERIOD_NS - 1) / `PCFP_CLK_PERIOD_NS)

// register selection codes
`define PCFP_REG_OFS_COARSE 3'h0
`define PCFP_REG_OFS_FINE 3'h1
`define PCFP_REG_GAIN_COARSE 3'h2
`define PCFP_REG_GAIN_FINE 3'h3
`define PCFP_REG_TEMP_COEF 3'h4
`define PCFP_REG_CLAMP 3'h5
`define PCFP_REG_POLARITY 3'h6
`define PCFP_REG_LAST 3'h6

// mode selection counts
`define PCFP_MODE_CNT_NONE 2'h0
`define PCFP_MODE_CNT_TRY 2'h1
`define PCFP_MODE_CNT_BLOW 2'h2
`define PCFP_MODE_CNT_LOCK 2'h3

// highest value each register steps to before wrapping to zero
`define PCFP_LIM_OFS_COARSE 9'h002
`define PCFP_LIM_OFS_FINE 9'h1FF
`define PCFP_LIM_GAIN_COARSE 9'h002
`define PCFP_LIM_GAIN_FINE 9'h0FF
`define PCFP_LIM_TEMP_COEF 9'h01F
`define PCFP_LIM_CLAMP 9'h002
`define PCFP_LIM_POLARITY 9'h001

// fuse sense vector layout
`define PCFP_FUSE_W 29
`define PCFP_FLD_OFS_COARSE_LSB 0
`define PCFP_FLD_OFS_FINE_LSB 2
`define PCFP_FLD_GAIN_COARSE_LSB 11
`define PCFP_FLD_GAIN_FINE_LSB 13
`define PCFP_FLD_TEMP_COEF_LSB 21
`define PCFP_FLD_CLAMP_LSB 26
`define PCFP_FLD_POLARITY_LSB 28
`define PCFP_W_COARSE 2
`define PCFP_W_OFS_FINE 9
`define PCFP_W_GAIN_FINE 8
`define PCFP_W_TEMP_COEF 5
`define PCFP_W_CLAMP 2
`define PCFP_W_POLARITY 1

// widest register value and the number of registers
`define PCFP_VAL_W 9
`define PCFP_NUM_REGS 7
`define PCFP_VAL_ZERO 9'h000
`define PCFP_VAL_ONE 9'h001
`define PCFP_CNT_W 14

`endif

// ===== verilog/pcfp_pkg.sv
package pcfp_pkg;

  // filtered level on the output pin
  typedef enum logic [1:0] {
    PCFP_LVL_NONE,
    PCFP_LVL_LOW,
    PCFP_LVL_MID,
    PCFP_LVL_HIGH
  } pcfp_level_t;

  // programming state machine
  typedef enum logic [1:0] {
    PCFP_ST_INITIAL,
    PCFP_ST_MODE_SEL,
    PCFP_ST_REG_SEL,
    PCFP_ST_BITFIELD_SEL
  } pcfp_state_t;

endpackage

// ===== verilog/pcfp_level_filter.sv
`timescale 1ns/1ps
`include "pcfp_defines.svh"

module pcfp_level_filter
  import pcfp_pkg::*;
#(
  parameter int unsigned LOW_CYC = `PCFP_NS_TO_CYC(`PCFP_T_LOW_ADDR_NS),
  parameter int unsigned MID_CYC = `PCFP_NS_TO_CYC(`PCFP_T_MID_ADDR_NS),
  parameter int unsigned HIGH_CYC = `PCFP_NS_TO_CYC(`PCFP_T_STATE_HIGH_NS)
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-up reset
  input wire logic over_low_thr, // pin above low band
  input wire logic over_mid_thr, // pin in mid band or above
  input wire logic over_high_thr, // pin in high band
  output pcfp_level_t level_q, // accepted level
  output logic level_ev_q // pulse: level just accepted
);

  logic [`PCFP_CNT_W-1:0] cnt_q; // cycles the candidate has persisted
  pcfp_level_t cand_q; // level currently being timed
  pcfp_level_t raw; // unfiltered class of the pin

  // cycles a level must persist, less one
  function automatic logic [`PCFP_CNT_W-1:0] need(input pcfp_level_t l);
    unique case (l)
      PCFP_LVL_LOW: need = `PCFP_CNT_W'(LOW_CYC - 1);
      PCFP_LVL_MID: need = `PCFP_CNT_W'(MID_CYC - 1);
      PCFP_LVL_HIGH: need = `PCFP_CNT_W'(HIGH_CYC - 1);
      PCFP_LVL_NONE: need = '1;
    endcase
  endfunction

  // three-level classification; the gap between bands is no symbol
  // level bands
  always_comb begin
    if (over_high_thr) begin
      raw = PCFP_LVL_HIGH;
    end else if (over_mid_thr) begin
      raw = PCFP_LVL_MID;
    end else if (!over_low_thr) begin
      raw = PCFP_LVL_LOW;
    end else begin
      raw = PCFP_LVL_NONE;
    end
  end

  // persistence timer; any change of class restarts it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cand_q <= PCFP_LVL_NONE;
      cnt_q <= '0;
    end else if (raw != cand_q) begin
      cand_q <= raw;
      cnt_q <= '0;
    end else if (cnt_q != need(cand_q)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // accept a level once it has lasted long enough; glitches never get here
  // discard short excursions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_q <= PCFP_LVL_NONE;
      level_ev_q <= 1'b0;
    end else if (raw == cand_q && cand_q != PCFP_LVL_NONE && cnt_q == need(cand_q)
                 && cand_q != level_q) begin
      level_q <= cand_q;
      level_ev_q <= 1'b1;
    end else begin
      level_ev_q <= 1'b0;
    end
  end

endmodule // pcfp_level_filter

// ===== verilog/pcfp_programmer.sv
// Operation
// - high pulse rising edge advances state
// - high pulse dropping to low increments selection
// - fourth high pulse burns pending selection
// - classify pin as low, mid, high
// - mid to low transition counts one pulse
// - power-up gives initial state, intact bits zero
// - high pulse enters mode selection
// - low count picks try, blow, lock; wraps
// - high before any low ignored in mode
// - nonzero mode plus high enters register selection
// - low count picks one of seven registers
// - register widths 2,9,2,8,5,2,1 bits
// - high pulse enters bitfield selection
// - try mode low pulse adds one, visible
// - high returns to mode, blow burns first
// - lock burns device fuse, refuses programming
// - entering bitfield clears selected intact bits
// - power cycle clears intact, keeps burned bits
// - lock flag one bit, one means locked
`timescale 1ns/1ps
`include "pcfp_defines.svh"

module pcfp_programmer
  import pcfp_pkg::*;
#(
  parameter int unsigned LOW_CYC = `PCFP_NS_TO_CYC(`PCFP_T_LOW_ADDR_NS),
  parameter int unsigned MID_CYC = `PCFP_NS_TO_CYC(`PCFP_T_MID_ADDR_NS),
  parameter int unsigned HIGH_CYC = `PCFP_NS_TO_CYC(`PCFP_T_STATE_HIGH_NS)
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-up reset
  input wire logic pin_over_low_thr, // output pin above low band
  input wire logic pin_over_mid_thr, // output pin at mid band or above
  input wire logic pin_over_high_thr, // output pin in high band
  input wire logic [`PCFP_FUSE_W-1:0] fuse_sense, // burned bitfield fuses
  input wire logic lock_fuse_sense, // device lock fuse burned
  output logic [1:0] offset_coarse_range_q, // offset range code
  output logic [8:0] offset_fine_value_q, // offset fine code
  output logic [1:0] gain_coarse_range_q, // gain range code
  output logic [7:0] gain_fine_value_q, // gain fine code
  output logic [4:0] temp_coefficient_code_q, // temperature coefficient code
  output logic [1:0] output_clamp_select_q, // clamp code
  output logic output_polarity_select_q, // polarity code
  output logic locked_q, // device lock flag
  output pcfp_state_t prog_state_q, // programming state
  output logic fuse_burn_q, // burn energy gate for a bitfield
  output logic [2:0] fuse_burn_reg_q, // register being burned
  output logic [8:0] fuse_burn_mask_q, // bitfields being burned
  output logic lock_burn_q // burn energy gate for the lock fuse
);

  // filter outputs and the two events decoded from them
  pcfp_level_t lvl; // filtered pin level
  logic lvl_ev; // pulse: new level accepted
  logic high_ev; // state change event
  logic low_ev; // increment event
  // selection counts of the three addressing states
  logic [1:0] mode_cnt_q; // mode selection count
  logic mode_seen_low_q; // a low pulse arrived in mode selection
  logic [2:0] reg_sel_q; // register selection count
  logic [`PCFP_VAL_W-1:0] bf_code_q; // bitfield code for blow and lock modes
  logic [`PCFP_VAL_W-1:0] trim_vol_q [`PCFP_NUM_REGS]; // provisional values
  // lock state: the fuse itself or a burn started in this session
  logic lock_burned_q; // lock fuse burned in this power cycle
  logic locked; // lock from fuse or from this session
  // per-register views, all padded to the widest register
  logic [`PCFP_VAL_W-1:0] fused_val [`PCFP_NUM_REGS]; // burned bits per register
  logic [`PCFP_VAL_W-1:0] eff_val [`PCFP_NUM_REGS]; // value seen by the analog side

  // highest value of a register before it wraps to zero
  function automatic logic [`PCFP_VAL_W-1:0] reg_limit(input logic [2:0] sel);
    unique case (sel)
      // coarse and clamp stop at code 2; code 3 would only wrap
      `PCFP_REG_OFS_COARSE: reg_limit = `PCFP_LIM_OFS_COARSE;
      `PCFP_REG_OFS_FINE: reg_limit = `PCFP_LIM_OFS_FINE;
      `PCFP_REG_GAIN_COARSE: reg_limit = `PCFP_LIM_GAIN_COARSE;
      `PCFP_REG_GAIN_FINE: reg_limit = `PCFP_LIM_GAIN_FINE;
      `PCFP_REG_TEMP_COEF: reg_limit = `PCFP_LIM_TEMP_COEF;
      `PCFP_REG_CLAMP: reg_limit = `PCFP_LIM_CLAMP;
      `PCFP_REG_POLARITY: reg_limit = `PCFP_LIM_POLARITY;
      // code 7 is never selected; treat as a one-bit register
      default: reg_limit = `PCFP_LIM_POLARITY;
    endcase
  endfunction

  // step a register value by one with its own wrap point
  function automatic logic [`PCFP_VAL_W-1:0] step_val(input logic [`PCFP_VAL_W-1:0] v,
                                                      input logic [2:0] sel);
    if (v >= reg_limit(sel)) begin
      // wrap at the register's own top code, not at the word width
      step_val = `PCFP_VAL_ZERO;
    end else begin
      // plain step; the limit keeps it inside the register's width
      step_val = v + `PCFP_VAL_ONE;
    end
  endfunction

  // level detector with persistence filter
  // only accepted levels reach the state machine, never raw comparator bits
  pcfp_level_filter #(
    .LOW_CYC(LOW_CYC),
    .MID_CYC(MID_CYC),
    .HIGH_CYC(HIGH_CYC)
  ) u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .over_low_thr(pin_over_low_thr),
    .over_mid_thr(pin_over_mid_thr),
    .over_high_thr(pin_over_high_thr),
    .level_q(lvl),
    .level_ev_q(lvl_ev)
  );

  // the arrival of an accepted high is the rising edge that changes state
  // high edge event
  assign high_ev = lvl_ev && (lvl == PCFP_LVL_HIGH);
  // a low accepted after mid or high; holding mid into the next high
  // produces no low, so no increment
  // mid to low pulse
  assign low_ev = lvl_ev && (lvl == PCFP_LVL_LOW);

  // the session bit covers the time until the burned fuse is sensed
  // lock comes from the fuse or from a lock burn earlier in this session
  // single lock bit
  assign locked = lock_fuse_sense | lock_burned_q;

  // fused bits of each register, then the value seen by the analog side
  // register widths
  always_comb begin
    for (int i = 0; i < `PCFP_NUM_REGS; i++) begin
      fused_val[i] = `PCFP_VAL_ZERO;
    end
    // each sense field lands in the low bits of its register
    fused_val[`PCFP_REG_OFS_COARSE][`PCFP_W_COARSE-1:0] =
      fuse_sense[`PCFP_FLD_OFS_COARSE_LSB +: `PCFP_W_COARSE];
    fused_val[`PCFP_REG_OFS_FINE][`PCFP_W_OFS_FINE-1:0] =
      fuse_sense[`PCFP_FLD_OFS_FINE_LSB +: `PCFP_W_OFS_FINE];
    fused_val[`PCFP_REG_GAIN_COARSE][`PCFP_W_COARSE-1:0] =
      fuse_sense[`PCFP_FLD_GAIN_COARSE_LSB +: `PCFP_W_COARSE];
    fused_val[`PCFP_REG_GAIN_FINE][`PCFP_W_GAIN_FINE-1:0] =
      fuse_sense[`PCFP_FLD_GAIN_FINE_LSB +: `PCFP_W_GAIN_FINE];
    fused_val[`PCFP_REG_TEMP_COEF][`PCFP_W_TEMP_COEF-1:0] =
      fuse_sense[`PCFP_FLD_TEMP_COEF_LSB +: `PCFP_W_TEMP_COEF];
    fused_val[`PCFP_REG_CLAMP][`PCFP_W_CLAMP-1:0] =
      fuse_sense[`PCFP_FLD_CLAMP_LSB +: `PCFP_W_CLAMP];
    fused_val[`PCFP_REG_POLARITY][`PCFP_W_POLARITY-1:0] =
      fuse_sense[`PCFP_FLD_POLARITY_LSB +: `PCFP_W_POLARITY];
  end

  // a burned fuse forces its bit to one whatever the provisional value is
  // limitation: a provisional value can only add bits to a burned field
  generate
    for (genvar g = 0; g < `PCFP_NUM_REGS; g++) begin : g_eff
      assign eff_val[g] = fused_val[g] | trim_vol_q[g];
    end
  endgenerate

  // programming state machine; a locked device never leaves initial
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_state_q <= PCFP_ST_INITIAL;
    end else if (locked) begin
      prog_state_q <= PCFP_ST_INITIAL;
    end else if (high_ev) begin
      // only a high moves the state; lows only step the counts
      unique case (prog_state_q)
        PCFP_ST_INITIAL: begin
          // one high is enough, whatever lows came before
          prog_state_q <= PCFP_ST_MODE_SEL;
        end
        PCFP_ST_MODE_SEL: begin
          // a count wrapped back to zero names no mode, so the high is dropped
          if (mode_seen_low_q && mode_cnt_q != `PCFP_MODE_CNT_NONE) begin
            prog_state_q <= PCFP_ST_REG_SEL;
          end
        end
        PCFP_ST_REG_SEL: begin
          // every register count is legal, so no check here
          prog_state_q <= PCFP_ST_BITFIELD_SEL;
        end
        PCFP_ST_BITFIELD_SEL: begin
          // burning and the count clear run in their own processes
          prog_state_q <= PCFP_ST_MODE_SEL;
        end
      endcase
    end
  end

  // mode count; it is cleared when the device comes back from bitfield
  // selection, so the next sequence must step it again from zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // no mode chosen and no low seen after power-up
      mode_cnt_q <= `PCFP_MODE_CNT_NONE;
      mode_seen_low_q <= 1'b0;
    end else if (!locked && prog_state_q == PCFP_ST_BITFIELD_SEL && high_ev) begin
      // a fresh mode count is needed after each sequence
      mode_cnt_q <= `PCFP_MODE_CNT_NONE;
      mode_seen_low_q <= 1'b0;
    end else if (!locked && prog_state_q == PCFP_ST_MODE_SEL && low_ev) begin
      // lows in initial state never get here
      mode_cnt_q <= mode_cnt_q + 2'h1;
      mode_seen_low_q <= 1'b1;
    end
  end

  // register selection count, cleared on entry to register selection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // register zero is the default target
      reg_sel_q <= `PCFP_REG_OFS_COARSE;
    end else if (!locked && prog_state_q == PCFP_ST_MODE_SEL && high_ev) begin
      // each register selection counts from zero again
      reg_sel_q <= `PCFP_REG_OFS_COARSE;
    end else if (!locked && prog_state_q == PCFP_ST_REG_SEL && low_ev) begin
      // register count wraps after the last
      if (reg_sel_q == `PCFP_REG_LAST) begin
        reg_sel_q <= `PCFP_REG_OFS_COARSE;
      end else begin
        reg_sel_q <= reg_sel_q + 3'h1;
      end
    end
  end

  // bitfield code for blow and lock modes; never reaches the analog side,
  // so a code search in these modes shows nothing until the fuse burns
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bf_code_q <= `PCFP_VAL_ZERO;
    end else if (!locked && prog_state_q == PCFP_ST_REG_SEL && high_ev) begin
      // a fresh code for every bitfield selection
      bf_code_q <= `PCFP_VAL_ZERO;
    end else if (!locked && prog_state_q == PCFP_ST_BITFIELD_SEL && low_ev
                 && mode_cnt_q != `PCFP_MODE_CNT_TRY) begin
      // blow and lock modes count here instead of in the trim
      bf_code_q <= step_val(bf_code_q, reg_sel_q);
    end
  end

  // provisional register values
  // fused bits are never stored here; the or with fused_val brings them back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PCFP_NUM_REGS; i++) begin
        trim_vol_q[i] <= `PCFP_VAL_ZERO;
      end
    end else if (!locked && prog_state_q == PCFP_ST_REG_SEL && high_ev) begin
      trim_vol_q[reg_sel_q] <= `PCFP_VAL_ZERO;
    end else if (!locked && prog_state_q == PCFP_ST_BITFIELD_SEL && low_ev
                 && mode_cnt_q == `PCFP_MODE_CNT_TRY) begin
      trim_vol_q[reg_sel_q] <= step_val(trim_vol_q[reg_sel_q], reg_sel_q);
    end
  end

  // burn gates open on the high pulse that leaves bitfield selection and
  // stay open while the high level lasts; the supply, not the logic,
  // decides how much energy the fuse gets
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fuse_burn_q <= 1'b0;
      fuse_burn_reg_q <= `PCFP_REG_OFS_COARSE;
      fuse_burn_mask_q <= `PCFP_VAL_ZERO;
      lock_burn_q <= 1'b0;
    end else if (!locked && prog_state_q == PCFP_ST_BITFIELD_SEL && high_ev) begin
      // blow mode burns before returning
      // code zero names no bitfield, so no burn is started
      if (mode_cnt_q == `PCFP_MODE_CNT_BLOW && bf_code_q != `PCFP_VAL_ZERO) begin
        fuse_burn_q <= 1'b1;
        fuse_burn_reg_q <= reg_sel_q;
        fuse_burn_mask_q <= bf_code_q;
      end
      // lock mode burns device fuse
      // the lock burn needs no code; any selection will do
      if (mode_cnt_q == `PCFP_MODE_CNT_LOCK) begin
        lock_burn_q <= 1'b1;
      end
    end else if (lvl_ev && lvl != PCFP_LVL_HIGH) begin
      // the high pulse has ended
      // the register index is kept so the last burn can still be read
      fuse_burn_q <= 1'b0;
      fuse_burn_mask_q <= `PCFP_VAL_ZERO;
      lock_burn_q <= 1'b0;
    end
  end

  // the session lock takes effect as soon as the lock burn starts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // after a power cycle the lock fuse sense takes over
      lock_burned_q <= 1'b0;
    end else if (!locked && prog_state_q == PCFP_ST_BITFIELD_SEL && high_ev
                 && mode_cnt_q == `PCFP_MODE_CNT_LOCK) begin
      // set with the burn gate, so the state drops next edge
      lock_burned_q <= 1'b1;
    end
  end

  // registered outputs; the analog trim sees a new value one cycle late
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // all trims read zero until the first edge shows the fuses
      offset_coarse_range_q <= 2'h0;
      offset_fine_value_q <= 9'h000;
      gain_coarse_range_q <= 2'h0;
      gain_fine_value_q <= 8'h00;
      temp_coefficient_code_q <= 5'h00;
      output_clamp_select_q <= 2'h0;
      output_polarity_select_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      // one flop after the or keeps the analog trim free of glitches
      offset_coarse_range_q <= eff_val[`PCFP_REG_OFS_COARSE][`PCFP_W_COARSE-1:0];
      offset_fine_value_q <= eff_val[`PCFP_REG_OFS_FINE][`PCFP_W_OFS_FINE-1:0];
      gain_coarse_range_q <= eff_val[`PCFP_REG_GAIN_COARSE][`PCFP_W_COARSE-1:0];
      gain_fine_value_q <= eff_val[`PCFP_REG_GAIN_FINE][`PCFP_W_GAIN_FINE-1:0];
      temp_coefficient_code_q <= eff_val[`PCFP_REG_TEMP_COEF][`PCFP_W_TEMP_COEF-1:0];
      output_clamp_select_q <= eff_val[`PCFP_REG_CLAMP][`PCFP_W_CLAMP-1:0];
      output_polarity_select_q <= eff_val[`PCFP_REG_POLARITY][0];
      locked_q <= locked;
    end
  end

endmodule // pcfp_programmer

// ===== testbench/pcfp_programmer_checker.sv
`timescale 1ns/1ps

module pcfp_programmer_checker
  import pcfp_pkg::*;
#(
  parameter int unsigned HIGH_CYC = 2000
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-up reset
  input wire logic pin_over_high_thr, // pin in high band
  input wire logic lock_fuse_sense, // lock fuse burned
  input wire logic [8:0] offset_fine_value_q, // offset fine code
  input wire logic locked_q, // lock flag
  input pcfp_state_t prog_state_q, // programming state
  input wire logic fuse_burn_q, // bitfield burn gate
  input wire logic [8:0] fuse_burn_mask_q // bitfields being burned
);
  logic [15:0] hi_run_q; // cycles the pin has sat in the high band

  // saturating run length, so a long burn pulse cannot wrap back to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hi_run_q <= 16'h0000;
    end else if (!pin_over_high_thr) begin
      hi_run_q <= 16'h0000;
    end else if (hi_run_q != 16'hFFFF) begin
      hi_run_q <= hi_run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_init: assert property ($fell(rst) |-> prog_state_q == PCFP_ST_INITIAL)
    else $error("state not initial after reset");
  a_state_by_high: assert property (!$stable(prog_state_q) |->
    $past(hi_run_q, 2) >= HIGH_CYC - 1) else $error("state moved without a full high pulse");
  a_init_ignores_low: assert property (prog_state_q == PCFP_ST_INITIAL &&
    !$past(pin_over_high_thr) |=> prog_state_q == PCFP_ST_INITIAL)
    else $error("initial state left without a high pulse");
  a_fine_step: assert property ($changed(offset_fine_value_q) &&
    $past(prog_state_q, 2) == PCFP_ST_BITFIELD_SEL |->
    offset_fine_value_q == $past(offset_fine_value_q) + 9'h001)
    else $error("provisional value did not step by one");
  a_lock_sticky: assert property (locked_q |=> locked_q && $stable(offset_fine_value_q))
    else $error("locked device changed");
  a_lock_sense: assert property (lock_fuse_sense |=> locked_q)
    else $error("burned lock fuse not flagged");
  a_burn_start: assert property ($rose(fuse_burn_q) |->
    pin_over_high_thr && fuse_burn_mask_q != 9'h000) else $error("burn outside high pulse");
  a_burn_end: assert property ($fell(pin_over_high_thr) && fuse_burn_q |->
    ##[1:24] !fuse_burn_q) else $error("burn gate stuck after high pulse");
  a_mask_idle: assert property (!fuse_burn_q |-> fuse_burn_mask_q == 9'h000)
    else $error("burn mask set without burn gate");
endmodule // pcfp_programmer_checker

bind pcfp_programmer pcfp_programmer_checker #(.HIGH_CYC(HIGH_CYC)) pcfp_programmer_checker_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .pin_over_high_thr(pin_over_high_thr),
  .lock_fuse_sense(lock_fuse_sense),
  .offset_fine_value_q(offset_fine_value_q),
  .locked_q(locked_q),
  .prog_state_q(prog_state_q),
  .fuse_burn_q(fuse_burn_q),
  .fuse_burn_mask_q(fuse_burn_mask_q)
);

// ===== testbench/pcfp_supply_model.sv
`timescale 1ns/1ps

module pcfp_supply_model
  import pcfp_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-up reset
  input pcfp_level_t lvl_req, // level the bench asks for
  output logic over_low_thr, // pin above low band
  output logic over_mid_thr, // pin at mid band or above
  output logic over_high_thr // pin in high band
);
  pcfp_level_t cur_q; // level now on the pin
  logic gap_q; // pin slewing through the unused band
  pcfp_level_t shown; // level the comparators see

  // slewing supply
  // a swing across the low threshold spends one cycle in the unused band, which the
  // device must discard; idle drive sits at 5 V or below, so reset parks it low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_q <= PCFP_LVL_LOW;
      gap_q <= 1'b0;
    end else if (lvl_req != cur_q && !gap_q &&
                 ((lvl_req == PCFP_LVL_LOW) != (cur_q == PCFP_LVL_LOW))) begin
      gap_q <= 1'b1; // crossing the band between low and mid
    end else begin
      gap_q <= 1'b0;
      cur_q <= lvl_req;
    end
  end

  assign shown = gap_q ? PCFP_LVL_NONE : cur_q;
  assign over_low_thr = (shown != PCFP_LVL_LOW);
  assign over_mid_thr = (shown == PCFP_LVL_MID) || (shown == PCFP_LVL_HIGH);
  assign over_high_thr = (shown == PCFP_LVL_HIGH);
endmodule // pcfp_supply_model

// ===== testbench/tb_pulse_coded_fuse_programmer.sv
`timescale 1ns/1ps
`include "pcfp_defines.svh"

// compare one value, count it, report a difference at once
`define TB_CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_pulse_coded_fuse_programmer;
  import pcfp_pkg::*;

  logic clk_sys = 1'b0; // system clock
  logic rst = 1'b1; // power-up reset
  pcfp_level_t lvl_req = PCFP_LVL_LOW; // level asked of the supply
  logic [`PCFP_FUSE_W-1:0] fuse_sense = '0; // burned bitfield fuses
  logic lock_fuse_sense = 1'b0; // lock fuse burned
  logic ovl, ovm, ovh; // band comparators
  logic [1:0] ofs_c, gain_c, clamp; // coarse and clamp codes
  logic [8:0] ofs_f, burn_mask; // offset fine, burn mask
  logic [7:0] gain_f; // gain fine
  logic [4:0] tc; // temperature coefficient
  logic pol, locked_q, fuse_burn_q, lock_burn_q; // flags
  logic [2:0] burn_reg; // register under burn
  pcfp_state_t prog_state_q; // programming state
  int n_errors = 0; // mismatches
  int compares = 0; // comparisons made

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // short symbol times keep the run brief; high must outlast low
  pcfp_programmer #(.LOW_CYC(4), .MID_CYC(4), .HIGH_CYC(8)) pcfp_programmer_inst (
    .clk_sys(clk_sys), .rst(rst), .pin_over_low_thr(ovl), .pin_over_mid_thr(ovm),
    .pin_over_high_thr(ovh), .fuse_sense(fuse_sense), .lock_fuse_sense(lock_fuse_sense),
    .offset_coarse_range_q(ofs_c), .offset_fine_value_q(ofs_f), .gain_coarse_range_q(gain_c),
    .gain_fine_value_q(gain_f), .temp_coefficient_code_q(tc), .output_clamp_select_q(clamp),
    .output_polarity_select_q(pol), .locked_q(locked_q), .prog_state_q(prog_state_q),
    .fuse_burn_q(fuse_burn_q), .fuse_burn_reg_q(burn_reg), .fuse_burn_mask_q(burn_mask),
    .lock_burn_q(lock_burn_q));

  pcfp_supply_model pcfp_supply_model_inst (
    .clk_sys(clk_sys), .rst(rst), .lvl_req(lvl_req),
    .over_low_thr(ovl), .over_mid_thr(ovm), .over_high_thr(ovh));

  // verdict and end of run
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // level hold: every level outlasts its minimum time
  task automatic drive(input pcfp_level_t l, input int n);
    lvl_req <= l;
    repeat (n) @(posedge clk_sys);
  endtask

  // high pulse then mid, so no increment follows
  task automatic hi();
    drive(PCFP_LVL_HIGH, 14);
    drive(PCFP_LVL_MID, 10);
  endtask

  // k addressing pulses, each low then mid
  task automatic lo(input int k);
    repeat (k) begin
      drive(PCFP_LVL_LOW, 8);
      drive(PCFP_LVL_MID, 8);
    end
  endtask

  // mode count, high, register count, high: lands in bitfield selection
  task automatic sel(input int m, input int r);
    lo(m);
    hi();
    lo(r);
    hi();
  endtask

  // bounded wait for a state; running out ends the run
  task automatic expect_state(input pcfp_state_t s);
    int i;
    i = 0;
    while (prog_state_q !== s && i < 30) begin
      @(posedge clk_sys);
      i++;
    end
    `TB_CHECK(prog_state_q, s)
    if (prog_state_q !== s) begin
      summarize();
    end
  endtask

  // power cycle with the given fuses burned
  task automatic power(input logic [`PCFP_FUSE_W-1:0] fs, input logic lk);
    rst <= 1'b1;
    fuse_sense <= fs;
    lock_fuse_sense <= lk;
    lvl_req <= PCFP_LVL_LOW;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end

  initial begin
    @(posedge clk_sys);
    power('0, 1'b0);
    `TB_CHECK(prog_state_q, PCFP_ST_INITIAL)
    `TB_CHECK(ofs_f, 9'h000)
    lo(2);
    `TB_CHECK(prog_state_q, PCFP_ST_INITIAL)
    hi();
    expect_state(PCFP_ST_MODE_SEL);
    hi();
    `TB_CHECK(prog_state_q, PCFP_ST_MODE_SEL)
    // five lows wrap the mode count round to provisional mode
    lo(5);
    hi();
    expect_state(PCFP_ST_REG_SEL);
    lo(1);
    hi();
    expect_state(PCFP_ST_BITFIELD_SEL);
    lo(3);
    `TB_CHECK(ofs_f, 9'h003)
    hi();
    expect_state(PCFP_ST_MODE_SEL);
    `TB_CHECK(ofs_f, 9'h003)
    // four steps of a coarse register: 1, 2, wrap to 0, then 1
    sel(1, 2);
    lo(4);
    `TB_CHECK(gain_c, 2'h1)
    hi();
    sel(1, 1);
    `TB_CHECK(ofs_f, 9'h000)
    hi();
    // high falling straight to low still counts one mode step
    drive(PCFP_LVL_HIGH, 14);
    drive(PCFP_LVL_LOW, 8);
    drive(PCFP_LVL_MID, 8);
    hi();
    expect_state(PCFP_ST_REG_SEL);
    hi();
    hi();
    // one bitfield: code 2 of the temperature coefficient
    sel(2, 4);
    lo(2);
    drive(PCFP_LVL_HIGH, 14);
    `TB_CHECK(fuse_burn_q, 1'b1)
    `TB_CHECK(burn_reg, 3'h4)
    `TB_CHECK(burn_mask, 9'h002)
    drive(PCFP_LVL_MID, 10);
    `TB_CHECK(fuse_burn_q, 1'b0)
    expect_state(PCFP_ST_MODE_SEL);
    // burned: coarse offset 1, gain fine 1, coefficient 2, clamp 2, polarity 1
    power(29'h1840_2001, 1'b0);
    `TB_CHECK(tc, 5'h02)
    `TB_CHECK(gain_c, 2'h0)
    `TB_CHECK(ofs_c, 2'h1)
    `TB_CHECK(gain_f, 8'h01)
    `TB_CHECK(clamp, 2'h2)
    `TB_CHECK(pol, 1'b1)
    hi();
    sel(3, 0);
    drive(PCFP_LVL_HIGH, 14);
    `TB_CHECK(lock_burn_q, 1'b1)
    drive(PCFP_LVL_MID, 10);
    `TB_CHECK(locked_q, 1'b1)
    hi();
    `TB_CHECK(prog_state_q, PCFP_ST_INITIAL)
    power('0, 1'b1);
    `TB_CHECK(locked_q, 1'b1)
    hi();
    `TB_CHECK(prog_state_q, PCFP_ST_INITIAL)
    summarize();
  end
endmodule // tb_pulse_coded_fuse_programmer
